//--- include/asc_regs.vh
// constants for the four-channel sampling converter control block
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
// control word bit positions (12 bits, msb first on the data input)
`define ASC_CW_WRITE      11
`define ASC_CW_SEQ_HI     10
`define ASC_CW_SEQ_LO     9
`define ASC_CW_CHAN_HI    7
`define ASC_CW_CHAN_LO    6
`define ASC_CW_PWR_HI     5
`define ASC_CW_PWR_LO     4
`define ASC_CW_RANGE      1
`define ASC_CW_CODING     0
`define ASC_CW_BITS       12
`define ASC_CW_RESET      12'h0_FF3
// transfer length and track point
`define ASC_XFER_BITS     5'h1_0
`define ASC_TRACK_EDGE    5'h0_E
`define ASC_CNT_ZERO      5'h0_0
`define ASC_CNT_ONE       5'h0_1
// power modes
`define ASC_PM_NORMAL     2'h3
`define ASC_PM_FULL_OFF   2'h2
`define ASC_PM_AUTO_OFF   2'h1
// sequence control codes and the coding msb flip mask
`define ASC_SEQ_START     2'h3
`define ASC_SEQ_KEEP      2'h2
`define ASC_CHAN_ZERO     2'h0
`define ASC_CHAN_STEP     2'h1
`define ASC_MSB_FLIP      12'h0_800
`endif

//--- logic/asc_control.v
// control logic of a four-channel 12-bit sampling converter behind a serial link
// Overview of operation
// - result word: 00, channel, 12-bit value
// - channel select bits route one input
// - sequence bits 1,1 convert ascending channels
// - first sequenced transfer converts channel zero
// - write with sequence 1,0 keeps sequence
// - sequence wraps to channel zero, repeats
// - power bits 1,1 keep fully powered
// - chip select fall starts conversion, hold
// - first 12 bits load control if write
// - sixteen clocks; track on 14th fall
// - power bits 1,0 shut down, keep control
// - wake from full off at select rise
// - wake transfer full length, output undriven
// - range bit picks single or double span
// - no sequence: channel from previous write
// - early select rise aborts, floats, no update
// - power bits 0,1 auto shutdown, wake on select
// - coding bit picks binary or twos complement
`timescale 1ns/10ps
`include "asc_regs.vh"
module asc_control
(
  input  wire        REF_CLK,
  input  wire        RESETN,
  input  wire        CS_N,
  input  wire        SCLK,
  input  wire        DIN,
  output reg         DOUT,
  output reg         DOUT_OE,
  output reg  [1:0]  MUX_SEL,
  output reg         HOLD,
  output reg         POWERED,
  output reg         RANGE_SINGLE,
  output reg         SAMPLE_REQ,
  input  wire        SAMPLE_READY,
  input  wire        SAMPLE_VALID,
  input  wire [11:0] SAMPLE_DATA,
  output reg  [11:0] CONTROL_WORD
);
  // synchronisers for the link pins
  reg [2:0] cs_sync_reg;
  reg [2:0] sclk_sync_reg;
  reg [1:0] din_sync_reg;
  always @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      cs_sync_reg   <= 3'h7;
      sclk_sync_reg <= 3'h0;
      din_sync_reg  <= 2'h0;
    end
    else
    begin
      cs_sync_reg   <= {cs_sync_reg[1:0], CS_N};
      sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
      din_sync_reg  <= {din_sync_reg[0], DIN};
    end
  end
  wire cs_fall   = cs_sync_reg[2] & ~cs_sync_reg[1];
  wire cs_rise   = ~cs_sync_reg[2] & cs_sync_reg[1];
  wire cs_low    = ~cs_sync_reg[1];
  wire sclk_rise = ~sclk_sync_reg[2] & sclk_sync_reg[1];
  wire sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];
  wire din_bit   = din_sync_reg[1];

  // two-entry buffer between converter core and shifter
  reg [11:0] buf_data_reg [0:1];
  reg        buf_wptr_reg;
  reg        buf_rptr_reg;
  reg [1:0]  buf_count_reg;
  wire       buf_in_ready  = (buf_count_reg != 2'h2);
  wire       buf_out_valid = (buf_count_reg != 2'h0);
  wire       buf_push      = SAMPLE_VALID & buf_in_ready;
  wire       buf_pop;
  always @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      buf_wptr_reg  <= 1'b0;
      buf_rptr_reg  <= 1'b0;
      buf_count_reg <= 2'h0;
    end
    else
    begin
      if (buf_push)
      begin
        buf_data_reg[buf_wptr_reg] <= SAMPLE_DATA;
        buf_wptr_reg <= ~buf_wptr_reg;
      end
      if (buf_pop)
        buf_rptr_reg <= ~buf_rptr_reg;
      buf_count_reg <= buf_count_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  reg  [4:0]  bit_cnt_reg;
  reg  [11:0] shift_in_reg;
  reg  [15:0] shift_out_reg;
  reg         active_reg;
  reg         loaded_reg;
  reg         waking_reg;
  reg         seq_run_reg;
  reg  [1:0]  conv_chan_reg;
  reg  [1:0]  seq_next_reg;
  wire [1:0]  pm_bits = CONTROL_WORD[`ASC_CW_PWR_HI:`ASC_CW_PWR_LO];
  wire [1:0]  last_chan = CONTROL_WORD[`ASC_CW_CHAN_HI:`ASC_CW_CHAN_LO];
  wire        full_off = (pm_bits == `ASC_PM_FULL_OFF);
  // the word is taken once per transfer; a late core only delays the load, the link is never stalled
  assign buf_pop = active_reg & ~loaded_reg & buf_out_valid;
  wire [11:0] raw_value = buf_data_reg[buf_rptr_reg];
  wire [11:0] coded_value = CONTROL_WORD[`ASC_CW_CODING] ? raw_value
                                                        : raw_value ^ `ASC_MSB_FLIP;
  wire        xfer_done = (bit_cnt_reg == `ASC_XFER_BITS);
  wire        write_en  = shift_in_reg[`ASC_CW_WRITE];
  wire [1:0]  new_seq   = shift_in_reg[`ASC_CW_SEQ_HI:`ASC_CW_SEQ_LO];

  always @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      bit_cnt_reg   <= `ASC_CNT_ZERO;
      shift_in_reg  <= 12'h0_000;
      active_reg    <= 1'b0;
      loaded_reg    <= 1'b0;
      waking_reg    <= 1'b0;
      seq_run_reg   <= 1'b0;
      conv_chan_reg <= `ASC_CHAN_ZERO;
      seq_next_reg  <= `ASC_CHAN_ZERO;
      CONTROL_WORD  <= `ASC_CW_RESET;
      MUX_SEL       <= `ASC_CHAN_ZERO;
      SAMPLE_REQ    <= 1'b0;
    end
    else
    begin
      SAMPLE_REQ   <= 1'b0;
      if (cs_fall)
      begin
        active_reg  <= 1'b1;
        loaded_reg  <= 1'b0;
        bit_cnt_reg <= `ASC_CNT_ZERO;
        waking_reg  <= full_off;
        SAMPLE_REQ  <= ~full_off;
      end
      else if (active_reg & cs_low)
      begin
        if (~loaded_reg & buf_pop)
          loaded_reg <= 1'b1;
        if (sclk_rise & (bit_cnt_reg < `ASC_CW_BITS))
          shift_in_reg <= {shift_in_reg[10:0], din_bit};
        if (sclk_fall)
        begin
          bit_cnt_reg <= bit_cnt_reg + `ASC_CNT_ONE;
        end
      end
      else if (active_reg & cs_rise)
      begin
        active_reg <= 1'b0;
        if (xfer_done)
        begin
          if (write_en)
            CONTROL_WORD <= shift_in_reg;
          if (write_en & (new_seq == `ASC_SEQ_START))
          begin
            seq_run_reg  <= 1'b1;
            seq_next_reg <= `ASC_CHAN_ZERO;
          end
          else if (write_en & (new_seq != `ASC_SEQ_KEEP))
          begin
            seq_run_reg  <= 1'b0;
            seq_next_reg <= shift_in_reg[`ASC_CW_CHAN_HI:`ASC_CW_CHAN_LO];
          end
          else if (seq_run_reg & ~waking_reg)
          begin
            if (conv_chan_reg == last_chan)
              seq_next_reg <= `ASC_CHAN_ZERO;
            else
              seq_next_reg <= conv_chan_reg + `ASC_CHAN_STEP;
          end
          else if (write_en & ~seq_run_reg)
            // no sequence, channel of this write
            seq_next_reg <= shift_in_reg[`ASC_CW_CHAN_HI:`ASC_CW_CHAN_LO];
        end
      end
      if (~active_reg)
      begin
        conv_chan_reg <= seq_next_reg;
        MUX_SEL       <= seq_next_reg;
      end
    end
  end

  always @(posedge REF_CLK)
  begin
    if (!RESETN)
      RANGE_SINGLE <= 1'b1;
    else
      RANGE_SINGLE <= CONTROL_WORD[`ASC_CW_RANGE];
  end

  // track-and-hold: held from select fall until the 14th fall or an abort
  always @(posedge REF_CLK)
  begin
    if (!RESETN)
      HOLD <= 1'b0;
    else if (cs_fall)
    begin
      HOLD <= 1'b1;
    end
    else if (active_reg & cs_low & sclk_fall)
    begin
      // back to track on 14th fall
      if (bit_cnt_reg + `ASC_CNT_ONE == `ASC_TRACK_EDGE)
        HOLD <= 1'b0;
    end
    else if (active_reg & cs_rise)
      HOLD <= 1'b0;
  end

  // power state follows the mode written at the end of a full transfer
  always @(posedge REF_CLK)
  begin
    if (!RESETN)
      POWERED <= 1'b1;
    else if (cs_fall)
    begin
      // auto mode wakes on select fall
      if (pm_bits == `ASC_PM_AUTO_OFF)
        POWERED <= 1'b1;
    end
    else if (active_reg & cs_rise & xfer_done)
    begin
      if (write_en)
        POWERED <= (shift_in_reg[`ASC_CW_PWR_HI:`ASC_CW_PWR_LO] == `ASC_PM_NORMAL);
      else
        POWERED <= (pm_bits == `ASC_PM_NORMAL);
    end
  end

  // output shifter; the leading bit stands from load, so all sixteen bits
  // are seen before the 16th fall floats the line
  always @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      shift_out_reg <= 16'h0_000;
      DOUT          <= 1'b0;
      DOUT_OE       <= 1'b0;
    end
    else if (cs_fall)
    begin
      DOUT_OE <= ~full_off;
      DOUT    <= 1'b0;
    end
    else if (active_reg & cs_low)
    begin
      if (~loaded_reg & buf_pop)
      begin
        DOUT          <= 1'b0;
        shift_out_reg <= {1'b0, conv_chan_reg, coded_value, 1'b0};
      end
      if (sclk_fall)
      begin
        DOUT          <= shift_out_reg[15];
        shift_out_reg <= {shift_out_reg[14:0], 1'b0};
        if (bit_cnt_reg + `ASC_CNT_ONE == `ASC_XFER_BITS)
          DOUT_OE <= 1'b0;
      end
    end
    else if (active_reg & cs_rise)
    begin
      DOUT_OE <= 1'b0;
    end
  end
endmodule

//--- tb/asc_control_monitor.sv
// port assertions for the converter control block
`timescale 1ns/10ps
module asc_control_monitor
(
  input wire        REF_CLK,
  input wire        RESETN,
  input wire        CS_N,
  input wire        DOUT,
  input wire        DOUT_OE,
  input wire [1:0]  MUX_SEL,
  input wire        HOLD,
  input wire        POWERED,
  input wire        SAMPLE_REQ,
  input wire [11:0] CONTROL_WORD
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  property p_hold; $fell(CS_N) && CONTROL_WORD[5:4] != 2'h2 |-> ##[1:4] HOLD; endproperty
  a_hold: assert property (p_hold) else $error("no hold after select fall");
  property p_req; SAMPLE_REQ |=> !SAMPLE_REQ; endproperty
  a_req: assert property (p_req) else $error("request not a pulse");
  property p_cw; !$stable(CONTROL_WORD) |-> CS_N && $past(CS_N); endproperty
  a_cw: assert property (p_cw) else $error("control word moved in transfer");
  property p_mux; !$stable(MUX_SEL) |-> CS_N; endproperty
  a_mux: assert property (p_mux) else $error("channel moved in transfer");
  property p_off; CONTROL_WORD[5:4] == 2'h2 && $stable(CONTROL_WORD) |-> !POWERED; endproperty
  a_off: assert property (p_off) else $error("powered in full shutdown");
  property p_norm; CONTROL_WORD[5:4] == 2'h3 && $stable(CONTROL_WORD) |-> POWERED; endproperty
  a_norm: assert property (p_norm) else $error("unpowered in normal mode");
  property p_wake; CONTROL_WORD[5:4] == 2'h2 && !POWERED |-> !DOUT_OE; endproperty
  a_wake: assert property (p_wake) else $error("output driven on wake");
  property p_lead; $rose(DOUT_OE) |-> ##2 !DOUT; endproperty
  a_lead: assert property (p_lead) else $error("leading bit not zero");
  property p_float; $rose(CS_N) |-> ##[1:4] !DOUT_OE; endproperty
  a_float: assert property (p_float) else $error("output not floated");
  c_seq: cover property (CONTROL_WORD[10:9] == 2'h3);
  c_off: cover property ($fell(POWERED));
  c_out: cover property ($rose(DOUT_OE));
endmodule
bind asc_control asc_control_monitor mon_u (.REF_CLK(REF_CLK), .RESETN(RESETN), .CS_N(CS_N),
  .DOUT(DOUT), .DOUT_OE(DOUT_OE), .MUX_SEL(MUX_SEL), .HOLD(HOLD), .POWERED(POWERED),
  .SAMPLE_REQ(SAMPLE_REQ), .CONTROL_WORD(CONTROL_WORD));

//--- tb/asc_core_model.sv
// converter core stand-in, answers a request three cycles later
`timescale 1ns/10ps
module asc_core_model
(
  input  wire        clk,
  input  wire        req,
  input  wire [1:0]  chan,
  output reg         valid,
  output reg  [11:0] data
);
  reg [1:0] dly_reg = 2'h0;
  initial valid = 1'b0;
  always @(posedge clk)
  begin
    dly_reg <= {dly_reg[0], req};
    valid   <= dly_reg[1];
    data    <= {chan, 10'h15A};
  end
endmodule

//--- tb/tb_asc_control.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks = n_checks + 1; if ((a) !== (e)) begin errors = errors + 1; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module tb_asc_control;
  reg         clk      = 1'b0;
  reg         rstn     = 1'b0;
  reg         cs_n     = 1'b1;
  reg         sclk     = 1'b0;
  reg         din      = 1'b0;
  wire        dout, dout_oe, powered, rng, req, vld, hold;
  wire [1:0]  mux;
  wire [11:0] sdat, cw;
  reg  [15:0] rd;
  reg  [15:0] exp_w;
  integer     errors   = 0;
  integer     n_checks = 0;
  integer     t;
  // one keep write (sequence 1,0) mid-sequence, power bits kept at 1,1
  localparam [95:0] WDS = {12'h8B3, 12'hEB2, 12'h000, 12'h000,
                           12'hCB2, 12'h000, 12'h8B3, 12'h8B1};
  localparam [15:0] CHS = {2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
  localparam [7:0]  FLP = 8'h3E;
  always #2.5 clk = ~clk;
  asc_control dut_u (.REF_CLK(clk), .RESETN(rstn), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .DOUT(dout), .DOUT_OE(dout_oe), .MUX_SEL(mux), .HOLD(hold), .POWERED(powered),
    .RANGE_SINGLE(rng), .SAMPLE_REQ(req), .SAMPLE_READY(1'b1), .SAMPLE_VALID(vld),
    .SAMPLE_DATA(sdat), .CONTROL_WORD(cw));
  asc_core_model core_u (.clk(clk), .req(req), .chan(mux), .valid(vld), .data(sdat));
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // nb serial clocks of 80 ns; fewer than 16 cuts the transfer short
  task xfer(input [11:0] w, input integer nb);
    integer k;
    begin
      @(posedge clk) cs_n <= 1'b0;
      cyc(20);
      for (k = 0; k < nb; k = k + 1)
      begin
        @(posedge clk) din <= (k < 12) ? w[11 - k] : 1'b0;
        cyc(6);
        @(posedge clk) sclk <= 1'b1;
        cyc(7);
        rd = {rd[14:0], dout};
        @(posedge clk) sclk <= 1'b0;
      end
      cyc(6);
      @(posedge clk) cs_n <= 1'b1;
      // select idles high, edges over 5 us apart
      cyc(1000);
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    rd = 16'h0000;
    cyc(10);
    rstn <= 1'b1;
    cyc(2);
    // plain writes, sequence start, wrap, keep and stop
    for (t = 0; t < 8; t = t + 1)
    begin
      xfer(WDS[12 * (7 - t) +: 12], 16);
      exp_w = {2'h0, CHS[2 * (7 - t) +: 2], CHS[2 * (7 - t) +: 2], 10'h15A};
      `CHK(rd, exp_w ^ {4'h0, FLP[7 - t], 11'h000})
    end
    `CHK(cw, 12'h8B1)
    `CHK(rng, 1'b0)
    `CHK(hold, 1'b0)
    xfer(12'h8A3, 6);
    `CHK(cw, 12'h8B1)
    `CHK(dout_oe, 1'b0)
    xfer(12'h8A3, 16);
    `CHK(powered, 1'b0)
    `CHK(cw, 12'h8A3)
    xfer(12'h8B3, 16);
    `CHK(powered, 1'b1)
    `CHK(cw, 12'h8B3)
    xfer(12'h893, 16);
    `CHK(powered, 1'b0)
    xfer(12'h000, 16);
    `CHK(rd, 16'h295A)
    `CHK(powered, 1'b0)
    close_out;
  end
  // hang guard
  initial
  begin
    #200000;
    errors = errors + 1;
    close_out;
  end
endmodule
